// ### rtl/wake_pkg.sv
// package: constants and types for the gpio wake-up controller
package wake_pkg;
   localparam int          LINE_COUNT     = 37;
   localparam int          DEB_WIDTH      = 6;
   localparam int          SYNC_STAGES    = 3;
   localparam int          CLK_HZ         = 25000000;
   localparam int          MS_PER_TICK    = 1;
   localparam int          MS_CYCLES      = (CLK_HZ / 1000) * MS_PER_TICK;
   localparam int          MS_CNT_WIDTH   = 15;
   localparam logic [14:0] MS_CNT_LAST    = 15'(MS_CYCLES - 1);
   localparam logic [5:0]  DEB_RESET_VAL  = 6'h00;
   localparam logic [36:0] LINES_RESET    = 37'h0;

   typedef enum logic [2:0] {
      DEB_IDLE  = 3'b001,
      DEB_COUNT = 3'b010,
      DEB_FIRE  = 3'b100
   } deb_state_type;

   typedef struct packed {
      logic        irq_allow;
      logic        clockless;
      logic [5:0]  debounce_reload;
   } wake_control_type;
endpackage

// ### rtl/line_sync.sv
// per-line synchroniser with stability filter on the sleep clock
`timescale 1ns/10ps
module line_sync
   import wake_pkg::*;
(
   input  wire logic                  clock_i,
   input  wire logic                  nrst_i,
   input  wire logic [LINE_COUNT-1:0] lines_i,
   output logic      [LINE_COUNT-1:0] stable_o
);
   logic [LINE_COUNT-1:0] meta_r;
   logic [LINE_COUNT-1:0] sync_r;
   logic [LINE_COUNT-1:0] hist1_r;
   logic [LINE_COUNT-1:0] hist2_r;

   always_ff @(posedge clock_i) begin
      if (!nrst_i) begin
         meta_r <= LINES_RESET;
         sync_r <= LINES_RESET;
      end else begin
         meta_r <= lines_i;
         sync_r <= meta_r;
      end
   end

   // stable output changes only after 3 equal samples
   genvar g;
   generate
      for (g = 0; g < LINE_COUNT; g++) begin : gen_line
         always_ff @(posedge clock_i) begin
            if (!nrst_i) begin
               hist1_r[g]  <= 1'b0;
               hist2_r[g]  <= 1'b0;
               stable_o[g] <= 1'b0;
            end else begin
               hist1_r[g] <= sync_r[g];
               hist2_r[g] <= hist1_r[g];
               if (sync_r[g] == hist1_r[g] && hist1_r[g] == hist2_r[g]) begin
                  stable_o[g] <= hist2_r[g];
               end
            end
         end
      end
   endgenerate
endmodule

// ### rtl/gpio_wakeup_controller.sv
// gpio wake-up controller: debounce path, edge latches and wake interrupt
//
// How it works
// - wakes from clocked and clockless sleep
// - clockless: any active debounce- or edge-selected line restarts clock
// - clocked: synchronised, stable three sleep clocks
// - all 37 lines can be monitored
// - per-line polarity xor selects active level
// - debounce-selected lines, time 0 to 63 ms
// - counter reloads, ticks per ms, fires at zero
// - edge-selected lines latch active edges
// - or of latched edges raises interrupt
// - allow bit and edge select mask interrupt
// - acknowledge write clears pending interrupt only when no selected edge latch or debounce fire remains
// - latch clear writes clear edge bits
// - no edge capture without running clock
// - interrupt goes to wake-up interrupt collector
`timescale 1ns/10ps
module gpio_wakeup_controller
   import wake_pkg::*;
(
   input  wire logic                  clock_i,
   input  wire logic                  nrst_i,
   input  wire logic [LINE_COUNT-1:0] gpio_lines_i,
   input  wire logic [LINE_COUNT-1:0] line_polarity_regs_i,
   input  wire logic [LINE_COUNT-1:0] debounce_select_regs_i,
   input  wire logic [LINE_COUNT-1:0] edge_select_regs_i,
   input  wire wake_control_type      wake_control_i,
   input  wire logic                  interrupt_acknowledge_i,
   input  wire logic [LINE_COUNT-1:0] latch_clear_regs_i,
   output logic [LINE_COUNT-1:0]      edge_latch_status_o,
   output logic                       wake_line_irq_o,
   output logic                       clock_restart_o
);
   // ----------------------------------------------------------------
   // input conditioning
   // ----------------------------------------------------------------
   logic [LINE_COUNT-1:0] stable_lines;
   logic [LINE_COUNT-1:0] active_lines;
   logic [LINE_COUNT-1:0] active_prev_r;
   logic [LINE_COUNT-1:0] rise_lines;
   logic [LINE_COUNT-1:0] raw_active;

   line_sync u_sync (
      .clock_i  (clock_i),
      .nrst_i   (nrst_i),
      .lines_i  (gpio_lines_i),
      .stable_o (stable_lines)
   );

   assign active_lines = stable_lines ^ line_polarity_regs_i;
   assign raw_active   = gpio_lines_i ^ line_polarity_regs_i;
   assign rise_lines   = active_lines & ~active_prev_r;

   always_ff @(posedge clock_i) begin
      if (!nrst_i) begin
         // follow the live level so that an inverted idle line gives no false edge after reset
         active_prev_r <= active_lines;
      end else begin
         active_prev_r <= active_lines;
      end
   end

   // ----------------------------------------------------------------
   // clockless restart request
   // ----------------------------------------------------------------
   always_ff @(posedge clock_i) begin
      if (!nrst_i) begin
         clock_restart_o <= 1'b0;
      end else begin
         clock_restart_o <= wake_control_i.clockless &&
                            |(raw_active & (debounce_select_regs_i | edge_select_regs_i));
      end
   end

   // ----------------------------------------------------------------
   // millisecond tick
   // ----------------------------------------------------------------
   logic [MS_CNT_WIDTH-1:0] ms_cnt_r;
   logic                    ms_tick_r;

   always_ff @(posedge clock_i) begin
      if (!nrst_i) begin
         ms_cnt_r  <= '0;
         ms_tick_r <= 1'b0;
      end else if (ms_cnt_r == MS_CNT_LAST) begin
         ms_cnt_r  <= '0;
         ms_tick_r <= 1'b1;
      end else begin
         ms_cnt_r  <= ms_cnt_r + 15'h0001;
         ms_tick_r <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // debounce path
   // ----------------------------------------------------------------
   deb_state_type         deb_state_r;
   logic [DEB_WIDTH-1:0]  deb_cnt_r;
   logic                  deb_any;
   logic                  deb_fire;

   assign deb_any  = |(active_lines & debounce_select_regs_i);
   assign deb_fire = (deb_state_r == DEB_FIRE);

   always_ff @(posedge clock_i) begin
      if (!nrst_i) begin
         deb_state_r <= DEB_IDLE;
         deb_cnt_r   <= DEB_RESET_VAL;
      end else begin
         unique case (deb_state_r)
            DEB_IDLE: begin
               deb_cnt_r <= wake_control_i.debounce_reload;
               if (deb_any) begin
                  deb_state_r <= DEB_COUNT;
               end
            end
            DEB_COUNT: begin
               if (!deb_any) begin
                  deb_state_r <= DEB_IDLE;
               end else if (deb_cnt_r == 6'h00) begin
                  deb_state_r <= DEB_FIRE;
               end else if (ms_tick_r) begin
                  deb_cnt_r <= deb_cnt_r - 6'h01;
               end
            end
            DEB_FIRE: begin
               if (!deb_any) begin
                  deb_state_r <= DEB_IDLE;
               end
            end
            default: begin
               deb_state_r <= DEB_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // edge latches
   // ----------------------------------------------------------------
   logic [LINE_COUNT-1:0] edge_set;

   assign edge_set = rise_lines & edge_select_regs_i
                     & {LINE_COUNT{~wake_control_i.clockless}};

   always_ff @(posedge clock_i) begin
      if (!nrst_i) begin
         edge_latch_status_o <= LINES_RESET;
      end else begin
         edge_latch_status_o <= (edge_latch_status_o & ~latch_clear_regs_i)
                                | edge_set;
      end
   end

   // ----------------------------------------------------------------
   // wake interrupt
   // ----------------------------------------------------------------
   logic irq_pend_r;
   logic irq_cause;

   assign irq_cause = deb_fire
                      || |(edge_latch_status_o & edge_select_regs_i);

   always_ff @(posedge clock_i) begin
      if (!nrst_i) begin
         irq_pend_r <= 1'b0;
      end else if (irq_cause) begin
         irq_pend_r <= 1'b1;
      end else if (interrupt_acknowledge_i) begin
         irq_pend_r <= 1'b0;
      end
   end

   always_ff @(posedge clock_i) begin
      if (!nrst_i) begin
         wake_line_irq_o <= 1'b0;
      end else begin
         wake_line_irq_o <= (irq_pend_r || irq_cause)
                            && wake_control_i.irq_allow;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   irq_masked_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
      !$past(wake_control_i.irq_allow) |-> !wake_line_irq_o)
      else $error("interrupt seen while not allowed");

   edge_sets_irq_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
      (|(edge_latch_status_o & edge_select_regs_i) && wake_control_i.irq_allow)
      |=> wake_line_irq_o)
      else $error("latched edge did not raise interrupt");

   edge_latch_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
      (|edge_set) |=> ((edge_latch_status_o & $past(edge_set)) == $past(edge_set)))
      else $error("active edge not latched");

   latch_hold_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
      (latch_clear_regs_i == '0) |=>
      ((edge_latch_status_o & $past(edge_latch_status_o)) == $past(edge_latch_status_o)))
      else $error("edge bit dropped without clear");

   latch_clear_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
      (edge_set == '0 && latch_clear_regs_i != '0) |=>
      ((edge_latch_status_o & $past(latch_clear_regs_i)) == '0))
      else $error("latch clear ignored");

   no_edge_clockless_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
      wake_control_i.clockless |=>
      ((edge_latch_status_o & ~$past(edge_latch_status_o)) == '0))
      else $error("edge captured in clockless mode");

   ack_clears_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
      (interrupt_acknowledge_i && !irq_cause) |=> !irq_pend_r)
      else $error("acknowledge did not clear interrupt");

   deb_abort_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
      (deb_state_r == DEB_COUNT && !deb_any) |=> deb_state_r == DEB_IDLE)
      else $error("debounce not aborted on line drop");

   deb_expire_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
      (deb_state_r == DEB_COUNT && deb_any && deb_cnt_r == 6'h00) |=> deb_fire)
      else $error("debounce expiry did not fire");

   restart_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
      (wake_control_i.clockless && |(raw_active & edge_select_regs_i)) |=> clock_restart_o)
      else $error("clock restart missing");
endmodule

// ### test/gpio_source_model.sv
// model of the external buttons and sensors that drive the gpio lines
`timescale 1ns/10ps
module gpio_source_model
   import wake_pkg::*;
#(
   parameter int HOLD_CYCLES = 1500
)(
   input  wire logic                  clock_i,
   input  wire logic [LINE_COUNT-1:0] press_i,
   output logic      [LINE_COUNT-1:0] gpio_o
);
   int                    hold_r  = 0;
   logic [LINE_COUNT-1:0] level_r = '0;

   assign gpio_o = level_r;

   // every new level is held for the minimum pulse time before it may change
   always @(posedge clock_i) begin
      if (hold_r > 0) begin
         hold_r <= hold_r - 1;
      end else if (press_i !== level_r) begin
         level_r <= press_i;
         hold_r  <= HOLD_CYCLES - 1;
      end
   end
endmodule

// ### test/testbench.sv
// self-checking bench for the gpio wake-up controller
`timescale 1ns/10ps
module testbench import wake_pkg::*;;
   typedef struct {int ln; logic pol; logic sel; logic allow; logic st; logic irq;} row_type;
   logic                  clock_i = 1'b0;
   logic                  nrst_i  = 1'b0;
   logic [LINE_COUNT-1:0] press, gpio, pol, dsel, esel, clr, status;
   wake_control_type      ctl;
   logic                  ack, irq, restart;
   int                    n_fail = 0;
   int                    total_checks = 0;
   int                    cycles = 0;
   int                    k, ln;
   row_type rows [4] = '{'{0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1}, '{36, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1},
                         '{5, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0}, '{7, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0}};

   always #20 clock_i = ~clock_i;

   gpio_source_model #(.HOLD_CYCLES(4)) model (.clock_i(clock_i), .press_i(press), .gpio_o(gpio));

   gpio_wakeup_controller uut (
      .clock_i(clock_i), .nrst_i(nrst_i), .gpio_lines_i(gpio), .line_polarity_regs_i(pol),
      .debounce_select_regs_i(dsel), .edge_select_regs_i(esel), .wake_control_i(ctl),
      .interrupt_acknowledge_i(ack), .latch_clear_regs_i(clr), .edge_latch_status_o(status),
      .wake_line_irq_o(irq), .clock_restart_o(restart));

   task automatic chk(input logic [LINE_COUNT-1:0] seen, input logic [LINE_COUNT-1:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge clock_i);
   endtask

   task automatic pulse_ack();
      ack = 1'b1;
      cyc(1);
      ack = 1'b0;
   endtask

   task automatic pulse_clr(input logic [LINE_COUNT-1:0] m);
      clr = m;
      cyc(1);
      clr = '0;
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   always @(posedge clock_i) begin
      cycles <= cycles + 1;
      if (cycles == 90000) begin
         n_fail++;
         conclude();
      end
   end

   initial begin
      press = '0; pol = '0; dsel = '0; esel = '0; clr = '0; ack = 1'b0;
      ctl = '{irq_allow: 1'b1, clockless: 1'b0, debounce_reload: 6'h00};
      cyc(16);
      chk(status, '0);
      chk(irq, 1'b0);
      nrst_i = 1'b1;
      cyc(4);
      // edge path, one row per line
      foreach (rows[i]) begin
         ln = rows[i].ln;
         pol[ln] = rows[i].pol;
         esel[ln] = rows[i].sel;
         ctl.irq_allow = rows[i].allow;
         press = pol;
         cyc(12);
         pulse_clr('1);
         pulse_ack();
         press[ln] = ~pol[ln];
         for (k = 0; k < 15 && status[ln] !== 1'b1; k++) cyc(1);
         cyc(2);
         chk(status, 37'(rows[i].st) << ln);
         chk(irq, rows[i].irq);
         pulse_ack();
         cyc(2);
         chk(irq, rows[i].irq);
         press = pol;
         cyc(8);
         pulse_clr(37'h1 << ln);
         cyc(2);
         chk(status, '0);
         pulse_ack();
         cyc(3);
         chk(irq, 1'b0);
         pol = '0; esel = '0; press = '0;
      end
      // debounce, reload zero, interrupt holds until acknowledged
      ctl.irq_allow = 1'b1;
      dsel[2] = 1'b1;
      press[2] = 1'b1;
      for (k = 0; k < 20 && irq !== 1'b1; k++) cyc(1);
      chk(irq, 1'b1);
      chk(restart, 1'b0);
      press[2] = 1'b0;
      cyc(10);
      chk(irq, 1'b1);
      pulse_ack();
      cyc(3);
      chk(irq, 1'b0);
      // debounce, reload two, short drop restarts the count
      ctl.debounce_reload = 6'h02;
      press[2] = 1'b1;
      cyc(24000);
      press[2] = 1'b0;
      cyc(10);
      press[2] = 1'b1;
      cyc(24000);
      chk(irq, 1'b0);
      for (k = 0; k < 27000 && irq !== 1'b1; k++) cyc(1);
      chk(irq, 1'b1);
      press[2] = 1'b0;
      dsel = '0;
      cyc(8);
      pulse_ack();
      // clockless sleep: restart request, no edge capture
      ctl.clockless = 1'b1;
      esel[9] = 1'b1;
      press[9] = 1'b1;
      for (k = 0; k < 10 && restart !== 1'b1; k++) cyc(1);
      chk(restart, 1'b1);
      cyc(10);
      chk(status, '0);
      // mid-run reset with an inverted line idling high: no false edge after release
      ctl.clockless = 1'b0;
      esel = '0;
      pol[11] = 1'b1;
      press = pol;
      cyc(12);
      nrst_i = 1'b0;
      esel[11] = 1'b1;
      cyc(4);
      chk(irq, 1'b0);
      nrst_i = 1'b1;
      cyc(12);
      chk(status, '0);
      chk(irq, 1'b0);
      chk(restart, 1'b0);
      conclude();
   end
endmodule
